// ### core/ifeb_regs.svh
// Purpose: Offsets, field positions and reset values of the flag bank
// Assumes: Register port with 4-bit word address and 8-bit data
// Notes: Definitions only
`ifndef IFEB_REGS_SVH
`define IFEB_REGS_SVH

// Register offsets (word address)
`define IFEB_OFS_TBU 4'h0
`define IFEB_OFS_HALL 4'h1
`define IFEB_OFS_CAPADC 4'h2
`define IFEB_OFS_PWM 4'h3
`define IFEB_OFS_EDGE 4'h4
`define IFEB_OFS_STAT 4'h5
`define IFEB_OFS_MASK 4'h6

// Implemented bits of each flag/enable register, the edge select and the status/mask pair
`define IFEB_IMPL_TBU 8'hdd
`define IFEB_IMPL_HALL 8'h77
`define IFEB_IMPL_CAPADC 8'hff
`define IFEB_IMPL_PWM 8'hff
`define IFEB_IMPL_EDGE 8'h3f
`define IFEB_IMPL_IRQ 8'h0f

// Field positions: flags in the upper nibble, enables in the lower; Hall edge selects C, B, A at bits 5:4, 3:2, 1:0
`define IFEB_FLAG_LSB 4
`define IFEB_ENA_LSB 0
`define IFEB_EDGE_C_LSB 4
`define IFEB_EDGE_B_LSB 2
`define IFEB_EDGE_A_LSB 0

// Reset values
`define IFEB_RST_BANK 8'h00
`define IFEB_RST_EDGE 8'h00
`define IFEB_RST_IRQ 4'h0
`define IFEB_RST_RDATA 8'h00

`endif

// ### core/ifeb_pkg.sv
// Purpose: Types shared by the interrupt flag and enable bank
// Assumes: Offsets and reset values live in ifeb_regs.svh
// Notes: Nothing here is imported; users write ifeb_pkg::name
package ifeb_pkg;

    // Hall edge selector encoding
    typedef enum logic [1:0] {
        IFEB_EDGE_OFF,
        IFEB_EDGE_RISE,
        IFEB_EDGE_FALL,
        IFEB_EDGE_BOTH
    } ifeb_edge_e;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic timebase;
        logic group6;
        logic serial;
        logic capture_match;
        logic capture_overflow;
        logic adc_compare;
        logic adc_done;
        logic pwm_period;
        logic [2:0] pwm_duty;
    } ifeb_evt_s;

    // Gated requests toward the core, one nibble per register
    typedef struct packed {
        logic [3:0] tbu;
        logic [3:0] hall;
        logic [3:0] capadc;
        logic [3:0] pwm;
    } ifeb_req_s;

    // Group summary flags for the main interrupt registers
    typedef struct packed {
        logic hall;
        logic capadc;
        logic pwm;
    } ifeb_grp_s;

endpackage : ifeb_pkg

// ### core/ifeb_bank.sv
// Purpose: Interrupt request flags and enables for time base, group 6,
//          serial port, Hall inputs, capture timer, converter and PWM
// Assumes: All inputs synchronous to clock_i; events are one-cycle pulses
// Notes: Four flag/enable banks plus edge select, status and mask
//
// Summary of operation
// - Group 6 flag at bit 6, its enable at bit 2.
// - Serial event sets flag bit 4; one means pending.
// - Serial request passes only while enable bit 0 is one.
// - Unimplemented bits always read back as zero.
// - Hall C, B, A flags at bits 6, 5, 4, set by own edges.
// - Hall C, B, A enables at bits 2, 1, 0.
// - Capture compare match sets bit 7; enable bit 3.
// - Capture overflow sets bit 6; enable bit 2.
// - Converter compare result sets bit 5; enable bit 1.
// - Conversion end sets bit 4; enable bit 0.
// - PWM period match sets bit 7; enable bit 3.
// - PWM duty matches 2, 1, 0 set bits 6, 5, 4; enables 2, 1, 0.
// - Hall edge select: 00 off, 01 rise, 10 fall, 11 both.
// - Hall, capture/converter and PWM groups each present one summary flag of their enabled requests; time base has none.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "ifeb_regs.svh"

module ifeb_bank #(
    parameter int ADDR_W = 4,
    parameter int NBANK = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Peripheral events and Hall levels
    input wire ifeb_pkg::ifeb_evt_s evt_i,
    input wire logic hall_c_event_i,
    input wire logic hall_b_event_i,
    input wire logic hall_a_event_i,
    // Requests toward the core
    output ifeb_pkg::ifeb_req_s req_o,
    output ifeb_pkg::ifeb_grp_s grp_o,
    output logic irq_o
);

    // Bank registers: 0 time base/serial, 1 Hall, 2 capture/adc, 3 PWM
    logic [7:0] bank_reg [NBANK];
    logic [7:0] bank_next [NBANK];
    logic [7:0] edge_reg;
    logic [7:0] edge_next;
    logic [2:0] hall_prev_reg;
    logic [3:0] stat_reg;
    logic [3:0] stat_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    logic [3:0] req_prev_reg [NBANK];
    logic [7:0] rdata_next;

    // Combinational helpers
    logic [7:0] impl_mask [NBANK];
    logic [3:0] bank_evt [NBANK];
    logic [3:0] bank_req [NBANK];
    logic [3:0] bank_rise;
    logic [ADDR_W-1:0] bank_ofs [NBANK];
    logic [NBANK-1:0] bank_wr;
    logic [2:0] hall_now;
    logic [2:0] hall_hit;
    logic [1:0] hall_sel [3];
    logic [1:0] hall_c_edge_select;
    logic [1:0] hall_b_edge_select;
    logic [1:0] hall_a_edge_select;
    logic edge_wr;
    logic stat_wr;
    logic mask_wr;

    // Address decode
    assign bank_ofs[0] = ADDR_W'(`IFEB_OFS_TBU);
    assign bank_ofs[1] = ADDR_W'(`IFEB_OFS_HALL);
    assign bank_ofs[2] = ADDR_W'(`IFEB_OFS_CAPADC);
    assign bank_ofs[3] = ADDR_W'(`IFEB_OFS_PWM);
    assign edge_wr = wr_i && (addr_i == ADDR_W'(`IFEB_OFS_EDGE));
    assign stat_wr = wr_i && (addr_i == ADDR_W'(`IFEB_OFS_STAT));
    assign mask_wr = wr_i && (addr_i == ADDR_W'(`IFEB_OFS_MASK));

    assign impl_mask[0] = `IFEB_IMPL_TBU;
    assign impl_mask[1] = `IFEB_IMPL_HALL;
    assign impl_mask[2] = `IFEB_IMPL_CAPADC;
    assign impl_mask[3] = `IFEB_IMPL_PWM;

    // Hall edge selectors per input, C then B then A
    assign hall_c_edge_select = edge_reg[`IFEB_EDGE_C_LSB +: 2];
    assign hall_b_edge_select = edge_reg[`IFEB_EDGE_B_LSB +: 2];
    assign hall_a_edge_select = edge_reg[`IFEB_EDGE_A_LSB +: 2];
    assign hall_sel[2] = hall_c_edge_select;
    assign hall_sel[1] = hall_b_edge_select;
    assign hall_sel[0] = hall_a_edge_select;
    assign hall_now = {hall_c_event_i, hall_b_event_i, hall_a_event_i};

    generate
        for (genvar h = 0; h < 3; h++) begin : g_hall
            logic rise;
            logic fall;
            assign rise = hall_now[h] && !hall_prev_reg[h];
            assign fall = !hall_now[h] && hall_prev_reg[h];
            assign hall_hit[h] =
                (hall_sel[h] == 2'(ifeb_pkg::IFEB_EDGE_RISE) && rise) ||
                (hall_sel[h] == 2'(ifeb_pkg::IFEB_EDGE_FALL) && fall) ||
                (hall_sel[h] == 2'(ifeb_pkg::IFEB_EDGE_BOTH) && (rise || fall));
        end
    endgenerate

    assign bank_evt[0] = {evt_i.timebase, evt_i.group6, 1'b0, evt_i.serial};
    assign bank_evt[1] = {1'b0, hall_hit};
    assign bank_evt[2] = {evt_i.capture_match, evt_i.capture_overflow,
                          evt_i.adc_compare, evt_i.adc_done};
    assign bank_evt[3] = {evt_i.pwm_period, evt_i.pwm_duty};

    // Flag and enable banks, same structure four times
    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            logic [7:0] base;
            assign bank_wr[b] = wr_i && (addr_i == bank_ofs[b]);
            assign base = bank_wr[b] ? wdata_i : bank_reg[b];
            // Event set wins over a clearing write in the same cycle
            assign bank_next[b] =
                (base | {bank_evt[b], 4'h0}) & impl_mask[b];
            assign bank_req[b] =
                bank_reg[b][`IFEB_FLAG_LSB +: 4] & bank_reg[b][`IFEB_ENA_LSB +: 4];
            assign bank_rise[b] = |(bank_req[b] & ~req_prev_reg[b]);

            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    bank_reg[b] <= `IFEB_RST_BANK;
                    req_prev_reg[b] <= 4'h0;
                end else begin
                    bank_reg[b] <= bank_next[b];
                    req_prev_reg[b] <= bank_req[b];
                end
            end
        end
    endgenerate

    // Edge select register
    assign edge_next = edge_wr ? (wdata_i & `IFEB_IMPL_EDGE) : edge_reg;

    // Sticky status, one bit per bank, set on a new request
    // Write one to clear; a new request in the same cycle keeps it set
    assign stat_next = (stat_reg & ~(stat_wr ? wdata_i[3:0] : 4'h0)) | bank_rise;
    assign mask_next = mask_wr ? wdata_i[3:0] : mask_reg;

    // Control registers; Hall history follows the pins so that
    // a level present at reset release is not taken as an edge
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            edge_reg <= `IFEB_RST_EDGE;
            stat_reg <= `IFEB_RST_IRQ;
            mask_reg <= `IFEB_RST_IRQ;
            hall_prev_reg <= hall_now;
        end else begin
            edge_reg <= edge_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            hall_prev_reg <= hall_now;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        case (addr_i)
            `IFEB_OFS_TBU: rdata_next = bank_reg[0];
            `IFEB_OFS_HALL: rdata_next = bank_reg[1];
            `IFEB_OFS_CAPADC: rdata_next = bank_reg[2];
            `IFEB_OFS_PWM: rdata_next = bank_reg[3];
            `IFEB_OFS_EDGE: rdata_next = edge_reg;
            `IFEB_OFS_STAT: rdata_next = {4'h0, stat_reg};
            `IFEB_OFS_MASK: rdata_next = {4'h0, mask_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= `IFEB_RST_RDATA;
        end else begin
            rdata_o <= rd_i ? rdata_next : 8'h00;
        end
    end

    // Named register fields, one wire per flag and enable
    // Time-base, group 6 and serial fields
    logic timebase_req_flag;
    logic timebase_req_enable;
    logic group6_req_flag;
    logic group6_req_enable;
    logic serial_req_flag;
    logic serial_req_enable;

    // Hall fields
    logic hall_c_req_flag;
    logic hall_b_req_flag;
    logic hall_a_req_flag;
    logic hall_c_req_enable;
    logic hall_b_req_enable;
    logic hall_a_req_enable;

    // Capture timer and converter fields
    logic capture_match_flag;
    logic capture_overflow_flag;
    logic adc_compare_flag;
    logic adc_done_flag;
    logic capture_match_enable;
    logic capture_overflow_enable;
    logic adc_compare_enable;
    logic adc_done_enable;

    // PWM fields
    logic pwm_period_flag;
    logic pwm_ch2_duty_flag;
    logic pwm_ch1_duty_flag;
    logic pwm_ch0_duty_flag;
    logic pwm_period_enable;
    logic pwm_ch2_duty_enable;
    logic pwm_ch1_duty_enable;
    logic pwm_ch0_duty_enable;

    // Time-base/serial register split into fields
    assign timebase_req_flag = bank_reg[0][`IFEB_FLAG_LSB + 3];
    assign group6_req_flag = bank_reg[0][`IFEB_FLAG_LSB + 2];
    assign serial_req_flag = bank_reg[0][`IFEB_FLAG_LSB + 0];
    assign timebase_req_enable = bank_reg[0][`IFEB_ENA_LSB + 3];
    assign group6_req_enable = bank_reg[0][`IFEB_ENA_LSB + 2];
    assign serial_req_enable = bank_reg[0][`IFEB_ENA_LSB + 0];

    // Hall register split into fields
    assign hall_c_req_flag = bank_reg[1][`IFEB_FLAG_LSB + 2];
    assign hall_b_req_flag = bank_reg[1][`IFEB_FLAG_LSB + 1];
    assign hall_a_req_flag = bank_reg[1][`IFEB_FLAG_LSB + 0];
    assign hall_c_req_enable = bank_reg[1][`IFEB_ENA_LSB + 2];
    assign hall_b_req_enable = bank_reg[1][`IFEB_ENA_LSB + 1];
    assign hall_a_req_enable = bank_reg[1][`IFEB_ENA_LSB + 0];

    // Capture/converter register split into fields
    assign capture_match_flag = bank_reg[2][`IFEB_FLAG_LSB + 3];
    assign capture_overflow_flag = bank_reg[2][`IFEB_FLAG_LSB + 2];
    assign adc_compare_flag = bank_reg[2][`IFEB_FLAG_LSB + 1];
    assign adc_done_flag = bank_reg[2][`IFEB_FLAG_LSB + 0];
    assign capture_match_enable = bank_reg[2][`IFEB_ENA_LSB + 3];
    assign capture_overflow_enable = bank_reg[2][`IFEB_ENA_LSB + 2];
    assign adc_compare_enable = bank_reg[2][`IFEB_ENA_LSB + 1];
    assign adc_done_enable = bank_reg[2][`IFEB_ENA_LSB + 0];

    // PWM register split into fields
    assign pwm_period_flag = bank_reg[3][`IFEB_FLAG_LSB + 3];
    assign pwm_ch2_duty_flag = bank_reg[3][`IFEB_FLAG_LSB + 2];
    assign pwm_ch1_duty_flag = bank_reg[3][`IFEB_FLAG_LSB + 1];
    assign pwm_ch0_duty_flag = bank_reg[3][`IFEB_FLAG_LSB + 0];
    assign pwm_period_enable = bank_reg[3][`IFEB_ENA_LSB + 3];
    assign pwm_ch2_duty_enable = bank_reg[3][`IFEB_ENA_LSB + 2];
    assign pwm_ch1_duty_enable = bank_reg[3][`IFEB_ENA_LSB + 1];
    assign pwm_ch0_duty_enable = bank_reg[3][`IFEB_ENA_LSB + 0];

    // request outputs, flag and enable per source
    // Built from registers only, so no glitch from the event pins
    assign req_o.tbu = {timebase_req_flag & timebase_req_enable,
                        group6_req_flag & group6_req_enable,
                        1'b0,
                        serial_req_flag & serial_req_enable};
    assign req_o.hall = {1'b0,
                         hall_c_req_flag & hall_c_req_enable,
                         hall_b_req_flag & hall_b_req_enable,
                         hall_a_req_flag & hall_a_req_enable};
    assign req_o.capadc = {capture_match_flag & capture_match_enable,
                           capture_overflow_flag & capture_overflow_enable,
                           adc_compare_flag & adc_compare_enable,
                           adc_done_flag & adc_done_enable};
    assign req_o.pwm = {pwm_period_flag & pwm_period_enable,
                        pwm_ch2_duty_flag & pwm_ch2_duty_enable,
                        pwm_ch1_duty_flag & pwm_ch1_duty_enable,
                        pwm_ch0_duty_flag & pwm_ch0_duty_enable};

    assign grp_o.hall = |bank_req[1];
    assign grp_o.capadc = |bank_req[2];
    assign grp_o.pwm = |bank_req[3];

    // Level interrupt while any unmasked status bit is set
    assign irq_o = |(stat_reg & mask_reg);

endmodule // ifeb_bank

// ### test/ifeb_src_model.sv
// Purpose: Peripheral event sources and Hall pins facing the bank
// Assumes: Bench asks for events one cycle ahead
// Notes: Registered like a real source, so pulses are one cycle long
`timescale 1ns/100ps
module ifeb_src_model (
    // Clock
    input wire logic clock_i,
    // Requests from the bench
    input wire ifeb_pkg::ifeb_evt_s cmd_i,
    input wire logic [2:0] hall_i,
    // Toward the bank
    output ifeb_pkg::ifeb_evt_s evt_o,
    output logic [2:0] hall_o
);
    always_ff @(posedge clock_i) begin
        evt_o <= cmd_i;
        hall_o <= hall_i;
    end
endmodule // ifeb_src_model

// ### test/ifeb_bank_checker.sv
// Purpose: Port-level checks on the flag and enable bank
// Assumes: One clock, synchronous reset
// Notes: Attached by bind below
`timescale 1ns/100ps
module ifeb_bank_checker #(
    parameter int ADDR_W = 4,
    parameter int NBANK = 4
) (
    // Clock, reset, register port
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Events and requests
    input wire ifeb_pkg::ifeb_evt_s evt_i,
    input wire ifeb_pkg::ifeb_req_s req_o,
    input wire ifeb_pkg::ifeb_grp_s grp_o,
    input wire logic irq_o
);
    // Request bits one cycle ago; only a new bit may raise the status
    logic [15:0] req_q;
    always_ff @(posedge clock_i) begin
        req_q <= req_o;
    end
    wire new_req = |(req_o & ~req_q);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_tbu_gap: assert property ($past(rd_i) && $past(addr_i) == 0 |-> (rdata_o & 8'h22) == 0)
        else $error("empty bits set");
    a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 6 |-> rdata_o == 0)
        else $error("unmapped read not zero");
    a_serial_cause: assert property ($rose(req_o.tbu[0]) |-> $past(evt_i.serial) || $past(wr_i))
        else $error("serial request without cause");
    a_done_cause: assert property ($rose(req_o.capadc[0]) |-> $past(evt_i.adc_done) || $past(wr_i))
        else $error("done request without cause");
    a_period_hold: assert property ($fell(req_o.pwm[3]) |-> $past(wr_i))
        else $error("period request dropped alone");
    a_grp_summary: assert property (grp_o == {|req_o.hall, |req_o.capadc, |req_o.pwm})
        else $error("group summary wrong");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(new_req) || $past(wr_i))
        else $error("interrupt without request");
endmodule // ifeb_bank_checker

bind ifeb_bank ifeb_bank_checker #(.ADDR_W(ADDR_W), .NBANK(NBANK)) chk_i (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i), .req_o(req_o),
    .grp_o(grp_o), .irq_o(irq_o));

// ### test/irq_flag_enable_bank_bench.sv
// Purpose: Register and event tests of the flag and enable bank
// Assumes: Read data one cycle after the read strobe
// Notes: Events come through the source model
`timescale 1ns/100ps
module irq_flag_enable_bank_bench;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [2:0] hall = 3'h0;
    logic [2:0] hl;
    logic [7:0] rdata;
    logic irq;
    ifeb_pkg::ifeb_evt_s cmd = '0;
    ifeb_pkg::ifeb_evt_s evt;
    ifeb_pkg::ifeb_req_s req;
    ifeb_pkg::ifeb_grp_s grp;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] impl [4] = '{8'hdd, 8'h77, 8'hff, 8'hff};

    // 50 MHz clock
    always #10 clock_i = ~clock_i;

    ifeb_src_model src (.clock_i(clock_i), .cmd_i(cmd), .hall_i(hall), .evt_o(evt), .hall_o(hl));
    ifeb_bank uut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .evt_i(evt), .hall_c_event_i(hl[2]),
        .hall_b_event_i(hl[1]), .hall_a_event_i(hl[0]), .req_o(req), .grp_o(grp), .irq_o(irq));

    task stop_test;
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One write (w=1) or one checked read (w=0)
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) chk(rdata, d);
    endtask

    // Fields msb first: tb, g6, serial, cmatch, covf, acmp, adone, period, duty2..0
    task ev(input logic [10:0] v);
        @(posedge clock_i);
        cmd <= v;
        @(posedge clock_i);
        cmd <= '0;
        repeat (2) @(posedge clock_i);
    endtask

    task hall_to(input logic [2:0] v);
        @(posedge clock_i);
        hall <= v;
        repeat (3) @(posedge clock_i);
    endtask

    // Hang guard, far above the 125 or so cycles needed
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test;
        end
    end

    initial begin
        repeat (5) @(posedge clock_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 7; i++) bus(1'b0, 4'(i), 8'h00);
        bus(1'b1, 4'hf, 8'hff);
        bus(1'b0, 4'hf, 8'h00);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 4'(i), 8'hff);
            bus(1'b0, 4'(i), impl[i]);
            bus(1'b1, 4'(i), 8'h00);
            bus(1'b0, 4'(i), 8'h00);
        end
        bus(1'b1, 4'h5, 8'hff);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 4'h0, 8'h0d);
        ev(11'h700);
        bus(1'b0, 4'h0, 8'hdd);
        chk({4'h0, req.tbu}, 8'h0d);
        bus(1'b1, 4'h0, 8'hdc);
        chk({4'h0, req.tbu}, 8'h0c);
        bus(1'b1, 4'h2, 8'h00);
        ev(11'h0f0);
        bus(1'b0, 4'h2, 8'hf0);
        chk({4'h0, req.capadc}, 8'h00);
        bus(1'b1, 4'h2, 8'hfa);
        chk({4'h0, req.capadc}, 8'h0a);
        chk({5'h0, grp}, 8'h02);
        bus(1'b1, 4'h3, 8'h05);
        ev(11'h00f);
        bus(1'b0, 4'h3, 8'hf5);
        chk({4'h0, req.pwm}, 8'h05);
        bus(1'b1, 4'h3, 8'h00);
        bus(1'b1, 4'h2, 8'h00);
        bus(1'b1, 4'h5, 8'hff);
        bus(1'b1, 4'h6, 8'h02);
        bus(1'b1, 4'h1, 8'h07);
        bus(1'b1, 4'h4, 8'h39);
        hall_to(3'h7);
        bus(1'b0, 4'h1, 8'h57);
        chk({4'h0, req.hall}, 8'h05);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, 4'h5, 8'h02);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 4'h1, 8'h07);
        hall_to(3'h0);
        bus(1'b0, 4'h1, 8'h67);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, 4'h6, 8'h00);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 4'h4, 8'h00);
        bus(1'b1, 4'h1, 8'h07);
        hall_to(3'h7);
        bus(1'b0, 4'h1, 8'h07);
        stop_test;
    end
endmodule // irq_flag_enable_bank_bench
